/* sccit_consts.vh */
// constants for the instruction timing sequencer: timing class codes,
// auxiliary-space access bases and stretch field widths.
// assumes one system clock, one counted execution cycle per clock period.
`ifndef SCCIT_CONSTS_VH
`define SCCIT_CONSTS_VH

// timing class codes presented with each issued instruction
`define SCCIT_CLS_W              6
`define SCCIT_MOV_A_BANK         6'h00
`define SCCIT_MOV_A_DIR          6'h01
`define SCCIT_MOV_A_IND          6'h02
`define SCCIT_MOV_A_IMM          6'h03
`define SCCIT_MOV_BANK_A         6'h04
`define SCCIT_MOV_BANK_DIR       6'h05
`define SCCIT_MOV_BANK_IMM       6'h06
`define SCCIT_MOV_DIR_A          6'h07
`define SCCIT_MOV_DIR_BANK       6'h08
`define SCCIT_MOV_DIR_DIR        6'h09
`define SCCIT_MOV_DIR_IND        6'h0a
`define SCCIT_MOV_DIR_IMM        6'h0b
`define SCCIT_MOV_IND_A          6'h0c
`define SCCIT_MOV_IND_DIR        6'h0d
`define SCCIT_MOV_IND_IMM        6'h0e
`define SCCIT_LOAD_PTR_IMM       6'h0f
`define SCCIT_CODE_READ_PTR      6'h10
`define SCCIT_CODE_READ_PC       6'h11
`define SCCIT_AUX_RD_8           6'h12
`define SCCIT_AUX_RD_16          6'h13
`define SCCIT_AUX_WR_8           6'h14
`define SCCIT_AUX_WR_16          6'h15
`define SCCIT_PUSH_DIR           6'h16
`define SCCIT_POP_DIR            6'h17
`define SCCIT_XCH_BANK           6'h18
`define SCCIT_XCH_DIR            6'h19
`define SCCIT_XCH_IND            6'h1a
`define SCCIT_LOW_NIBBLE_XCH     6'h1b
`define SCCIT_ARITH_BANK         6'h1c
`define SCCIT_ARITH_DIR          6'h1d
`define SCCIT_ARITH_IND          6'h1e
`define SCCIT_ARITH_IMM          6'h1f
`define SCCIT_LOGIC_A_BANK       6'h20
`define SCCIT_LOGIC_A_DIR        6'h21
`define SCCIT_LOGIC_A_IND        6'h22
`define SCCIT_LOGIC_A_IMM        6'h23
`define SCCIT_LOGIC_DIR_A        6'h24
`define SCCIT_LOGIC_DIR_IMM      6'h25
`define SCCIT_CLEAR_A            6'h26
`define SCCIT_COMPL_A            6'h27
`define SCCIT_ROT_LEFT           6'h28
`define SCCIT_ROT_LEFT_C         6'h29
`define SCCIT_ROT_RIGHT          6'h2a
`define SCCIT_ROT_RIGHT_C        6'h2b
`define SCCIT_SWAP_A             6'h2c

// widths of length, cycle and stretch fields
`define SCCIT_BYTES_W            2
`define SCCIT_CYC_W              5
`define SCCIT_ALE_STR_W          2
`define SCCIT_STB_STR_W          3

// auxiliary-space timing
`define SCCIT_AUX_ONCHIP_CYC     5'h03
`define SCCIT_XMEM_BASE_MUX      5'h05
`define SCCIT_XMEM_BASE_DEMUX    5'h03

`endif

/* sccit_timing.v */
// instruction length and execution-cycle sequencer of the core.
// the fetch logic presents one timing class per issue; this block holds
// it for the counted number of cycles and signals the next fetch.
`include "sccit_consts.vh"

module sccit_timing (
  // clock and reset
  input  wire                          clk_i,
  input  wire                          reset_n_i,
  // issue from fetch
  input  wire                          issue_i,
  input  wire [`SCCIT_CLS_W-1:0]       class_i,
  input  wire                          aux_external_i,
  // external bus stretch setup
  input  wire                          external_bus_mode_select_i,
  input  wire [`SCCIT_ALE_STR_W-1:0]   ale_stretch_i,
  input  wire [`SCCIT_STB_STR_W-1:0]   strobe_stretch_i,
  input  wire                          strobe_setup_hold_stretch_i,
  // sequencing
  output wire                          ready_o,
  output wire                          busy_o,
  output wire                          fetch_next_o,
  // status of the instruction in execution
  output reg  [`SCCIT_BYTES_W-1:0]     instr_bytes_o,
  output reg  [`SCCIT_CYC_W-1:0]       instr_cycles_o,
  output reg  [`SCCIT_CYC_W-1:0]       cycle_index_o,
  output reg  [`SCCIT_CLS_W-1:0]       class_o,
  output reg                           ext_access_o,
  output reg                           illegal_o
);

  reg  [`SCCIT_CYC_W-1:0]   remain_r;
  reg  [`SCCIT_CYC_W-1:0]   remain_nxt;
  reg  [`SCCIT_CYC_W-1:0]   index_nxt;
  reg  [`SCCIT_BYTES_W-1:0] bytes_lut;
  reg  [`SCCIT_CYC_W-1:0]   cycles_lut;
  reg                       aux_lut;
  reg                       illegal_lut;
  reg  [`SCCIT_CYC_W-1:0]   cycles_eff;
  wire [`SCCIT_CYC_W-1:0]   xmem_cycles;
  wire                      take;

  // remaining-cycle values that carry a meaning of their own
  localparam [`SCCIT_CYC_W-1:0] REMAIN_IDLE = 5'h00;
  localparam [`SCCIT_CYC_W-1:0] REMAIN_LAST = 5'h01;

  sccit_xmem_time u_xmem_time (
    .external_bus_mode_select_i  (external_bus_mode_select_i),
    .ale_stretch_i               (ale_stretch_i),
    .strobe_stretch_i            (strobe_stretch_i),
    .strobe_setup_hold_stretch_i (strobe_setup_hold_stretch_i),
    .access_cycles_o             (xmem_cycles)
  );

  // length and cycle table, keyed by timing class
  always @* begin
    bytes_lut   = 2'h1;
    cycles_lut  = 5'h01;
    aux_lut     = 1'b0;
    illegal_lut = 1'b0;
    case (class_i)
      // moves into the accumulator
      `SCCIT_MOV_A_BANK: begin
        bytes_lut  = 2'h1;
        cycles_lut = 5'h01;
      end
      `SCCIT_MOV_A_DIR,
      `SCCIT_MOV_A_IMM: begin
        bytes_lut  = 2'h2;
        cycles_lut = 5'h02;
      end
      `SCCIT_MOV_A_IND: begin
        bytes_lut  = 2'h1;
        cycles_lut = 5'h02;
      end
      // moves into bank registers
      `SCCIT_MOV_BANK_A: begin
        bytes_lut  = 2'h1;
        cycles_lut = 5'h02;
      end
      `SCCIT_MOV_BANK_DIR: begin
        bytes_lut  = 2'h2;
        cycles_lut = 5'h04;
      end
      `SCCIT_MOV_BANK_IMM: begin
        bytes_lut  = 2'h2;
        cycles_lut = 5'h02;
      end
      // moves into direct and indirect locations
      `SCCIT_MOV_DIR_A,
      `SCCIT_MOV_DIR_BANK,
      `SCCIT_MOV_IND_DIR,
      `SCCIT_MOV_IND_IMM: begin
        bytes_lut  = 2'h2;
        cycles_lut = 5'h03;
      end
      `SCCIT_MOV_DIR_DIR: begin
        bytes_lut  = 2'h3;
        cycles_lut = 5'h04;
      end
      `SCCIT_MOV_DIR_IND: begin
        bytes_lut  = 2'h2;
        cycles_lut = 5'h04;
      end
      `SCCIT_MOV_DIR_IMM: begin
        bytes_lut  = 2'h3;
        cycles_lut = 5'h03;
      end
      `SCCIT_MOV_IND_A: begin
        bytes_lut  = 2'h1;
        cycles_lut = 5'h03;
      end
      // data pointer, code space and auxiliary space
      `SCCIT_LOAD_PTR_IMM: begin
        bytes_lut  = 2'h3;
        cycles_lut = 5'h03;
      end
      `SCCIT_CODE_READ_PTR,
      `SCCIT_CODE_READ_PC: begin
        bytes_lut  = 2'h1;
        cycles_lut = 5'h04;
      end
      `SCCIT_AUX_RD_8,
      `SCCIT_AUX_RD_16,
      `SCCIT_AUX_WR_8,
      `SCCIT_AUX_WR_16: begin
        bytes_lut  = 2'h1;
        cycles_lut = `SCCIT_AUX_ONCHIP_CYC;
        aux_lut    = 1'b1;
      end
      // stack and exchanges
      `SCCIT_PUSH_DIR: begin
        bytes_lut  = 2'h2;
        cycles_lut = 5'h04;
      end
      `SCCIT_POP_DIR: begin
        bytes_lut  = 2'h2;
        cycles_lut = 5'h03;
      end
      `SCCIT_XCH_BANK: begin
        bytes_lut  = 2'h1;
        cycles_lut = 5'h03;
      end
      `SCCIT_XCH_DIR: begin
        bytes_lut  = 2'h2;
        cycles_lut = 5'h04;
      end
      `SCCIT_XCH_IND: begin
        bytes_lut  = 2'h1;
        cycles_lut = 5'h04;
      end
      `SCCIT_LOW_NIBBLE_XCH: begin
        bytes_lut  = 2'h1;
        cycles_lut = 5'h04;
      end
      // arithmetic and logic: the operation never changes the count,
      // only the operand kind does, so one class serves each kind
      `SCCIT_ARITH_BANK: begin
        bytes_lut  = 2'h1;
        cycles_lut = 5'h02;
      end
      `SCCIT_ARITH_IMM: begin
        bytes_lut  = 2'h2;
        cycles_lut = 5'h02;
      end
      `SCCIT_ARITH_DIR: begin
        bytes_lut  = 2'h2;
        cycles_lut = 5'h03;
      end
      `SCCIT_ARITH_IND: begin
        bytes_lut  = 2'h1;
        cycles_lut = 5'h03;
      end
      `SCCIT_LOGIC_A_BANK: begin
        bytes_lut  = 2'h1;
        cycles_lut = 5'h02;
      end
      `SCCIT_LOGIC_A_IMM: begin
        bytes_lut  = 2'h2;
        cycles_lut = 5'h02;
      end
      `SCCIT_LOGIC_A_DIR: begin
        bytes_lut  = 2'h2;
        cycles_lut = 5'h03;
      end
      `SCCIT_LOGIC_A_IND: begin
        bytes_lut  = 2'h1;
        cycles_lut = 5'h03;
      end
      `SCCIT_LOGIC_DIR_A: begin
        bytes_lut  = 2'h2;
        cycles_lut = 5'h04;
      end
      `SCCIT_LOGIC_DIR_IMM: begin
        bytes_lut  = 2'h3;
        cycles_lut = 5'h04;
      end
      // single-operand accumulator operations
      `SCCIT_CLEAR_A,
      `SCCIT_ROT_LEFT,
      `SCCIT_ROT_LEFT_C,
      `SCCIT_ROT_RIGHT,
      `SCCIT_ROT_RIGHT_C,
      `SCCIT_SWAP_A: begin
        bytes_lut  = 2'h1;
        cycles_lut = 5'h01;
      end
      `SCCIT_COMPL_A: begin
        bytes_lut  = 2'h1;
        cycles_lut = 5'h02;
      end
      default: begin
        // unknown classes run as a one-cycle filler so fetch never stalls
        bytes_lut   = 2'h1;
        cycles_lut  = 5'h01;
        illegal_lut = 1'b1;
      end
    endcase
  end

  // external auxiliary moves take their length from the stretch settings
  always @* begin
    if (aux_lut && aux_external_i) begin
      cycles_eff = xmem_cycles;
    end else begin
      cycles_eff = cycles_lut;
    end
  end

  // a new instruction may be taken in the cycle that fetches it, so
  // back-to-back instructions are spaced exactly by their cycle counts
  assign busy_o       = (remain_r != REMAIN_IDLE);
  assign fetch_next_o = (remain_r == REMAIN_LAST);
  assign ready_o      = !busy_o || fetch_next_o;
  assign take         = issue_i && ready_o;

  // next remaining count and position; a take restarts both
  always @* begin
    remain_nxt = remain_r;
    index_nxt  = cycle_index_o;
    if (take) begin
      remain_nxt = cycles_eff;
      index_nxt  = 5'h00;
    end else if (busy_o) begin
      remain_nxt = remain_r - 5'h01;
      if (remain_r != REMAIN_LAST) begin
        index_nxt = cycle_index_o + 5'h01;
      end
    end
  end

  // cycle counter and position inside the instruction
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      remain_r      <= REMAIN_IDLE;
      cycle_index_o <= 5'h00;
    end else begin
      remain_r      <= remain_nxt;
      cycle_index_o <= index_nxt;
    end
  end

  // status is loaded only at a take, so it keeps describing the
  // instruction in execution while fetch holds the next one back
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      instr_bytes_o  <= 2'h0;
      instr_cycles_o <= 5'h00;
      class_o        <= 6'h00;
      ext_access_o   <= 1'b0;
      illegal_o      <= 1'b0;
    end else if (take) begin
      instr_bytes_o  <= bytes_lut;
      instr_cycles_o <= cycles_eff;
      class_o        <= class_i;
      ext_access_o   <= aux_lut && aux_external_i;
      illegal_o      <= illegal_lut;
    end
  end

endmodule // sccit_timing

/* sccit_timing_assertions.sv */
// assertion checker for the instruction timing sequencer, bound to its ports.
// assumes one clock and a synchronous active-low reset.
`include "sccit_consts.vh"

module sccit_timing_chk (
  // clock and reset
  input wire       clk_i,
  input wire       reset_n_i,
  // issue and bus setup
  input wire       issue_i,
  input wire [5:0] class_i,
  input wire       aux_external_i,
  input wire       external_bus_mode_select_i,
  input wire [1:0] ale_stretch_i,
  input wire [2:0] strobe_stretch_i,
  input wire       strobe_setup_hold_stretch_i,
  // outputs
  input wire       ready_o,
  input wire       busy_o,
  input wire       fetch_next_o,
  input wire [1:0] instr_bytes_o,
  input wire [4:0] instr_cycles_o,
  input wire [4:0] cycle_index_o,
  input wire [5:0] class_o,
  input wire       ext_access_o,
  input wire       illegal_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  wire take = issue_i && ready_o;

  chk_take_class: assert property (take |=> class_o == $past(class_i))
    else $error("class not captured at take");
  chk_take_busy: assert property (take |=> busy_o)
    else $error("not busy after take");
  chk_ready_last: assert property (fetch_next_o && !issue_i |=> !busy_o && ready_o)
    else $error("busy past the last counted cycle");
  chk_last_index: assert property (fetch_next_o |-> cycle_index_o == instr_cycles_o - 5'h01)
    else $error("fetch not in counted last cycle");
  chk_dir_dir_four: assert property (take && class_i == `SCCIT_MOV_DIR_DIR
      |=> !fetch_next_o [*3] ##1 fetch_next_o)
    else $error("direct to direct move not four cycles");
  chk_clear_one: assert property (take && class_i == `SCCIT_CLEAR_A |=> fetch_next_o)
    else $error("clear not one cycle");
  chk_compl_two: assert property (take && class_i == `SCCIT_COMPL_A
      |=> !fetch_next_o ##1 fetch_next_o)
    else $error("complement not two cycles");
  chk_onchip_aux: assert property (take && class_i == `SCCIT_AUX_RD_8 && !aux_external_i
      |=> !fetch_next_o ##1 !fetch_next_o ##1 fetch_next_o)
    else $error("on-chip auxiliary move not three cycles");
  chk_ext_range: assert property (fetch_next_o && ext_access_o
      |-> instr_cycles_o >= 5'h03 && instr_cycles_o <= 5'h14)
    else $error("external move outside three to twenty");
  chk_code_read: assert property (take && class_i == `SCCIT_CODE_READ_PTR
      |=> instr_bytes_o == 2'h1 && instr_cycles_o == 5'h04)
    else $error("code read not one byte four cycles");

  cov_dir_dir: cover property (take && class_i == `SCCIT_MOV_DIR_DIR);
  cov_ext_move: cover property (fetch_next_o && ext_access_o);
  cov_back_to_back: cover property (fetch_next_o && issue_i);
endmodule // sccit_timing_chk

bind sccit_timing sccit_timing_chk chk_u (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .issue_i(issue_i), .class_i(class_i),
  .aux_external_i(aux_external_i), .external_bus_mode_select_i(external_bus_mode_select_i),
  .ale_stretch_i(ale_stretch_i), .strobe_stretch_i(strobe_stretch_i),
  .strobe_setup_hold_stretch_i(strobe_setup_hold_stretch_i), .ready_o(ready_o),
  .busy_o(busy_o), .fetch_next_o(fetch_next_o), .instr_bytes_o(instr_bytes_o),
  .instr_cycles_o(instr_cycles_o), .cycle_index_o(cycle_index_o), .class_o(class_o),
  .ext_access_o(ext_access_o), .illegal_o(illegal_o));

/* sccit_xmem_time.v */
// external auxiliary-space access time from the bus stretch settings.
// assumes the settings are steady while an access is being issued.
`include "sccit_consts.vh"

module sccit_xmem_time (
  // bus setup
  input  wire                          external_bus_mode_select_i,
  input  wire [`SCCIT_ALE_STR_W-1:0]   ale_stretch_i,
  input  wire [`SCCIT_STB_STR_W-1:0]   strobe_stretch_i,
  input  wire                          strobe_setup_hold_stretch_i,
  // result
  output reg  [`SCCIT_CYC_W-1:0]       access_cycles_o
);

  wire [`SCCIT_CYC_W-1:0] ale_x2;
  wire [`SCCIT_CYC_W-1:0] stb;
  wire [`SCCIT_CYC_W-1:0] sh_x2;

  assign ale_x2 = {2'b00, ale_stretch_i, 1'b0};
  assign stb    = {2'b00, strobe_stretch_i};
  assign sh_x2  = {3'b000, strobe_setup_hold_stretch_i, 1'b0};

  // mode low: address latch phase is present and stretched twice
  always @* begin
    if (!external_bus_mode_select_i) begin
      access_cycles_o = `SCCIT_XMEM_BASE_MUX + ale_x2 + stb + sh_x2;
    end else begin
      access_cycles_o = `SCCIT_XMEM_BASE_DEMUX + stb + sh_x2;
    end
  end

endmodule // sccit_xmem_time

/* single_clock_cpu_instruction_timing_test.sv */
// self-checking bench for the instruction timing sequencer.
// assumes the checker is bound separately; inputs move 1 ns after each edge.
`include "sccit_consts.vh"

module single_clock_cpu_instruction_timing_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [1:0] b; logic [4:0] c; logic [5:0] k; logic x; logic il;} sccit_note_t;
  // {bytes, cycles} per class code
  localparam logic [7:0] sccit_tbl [0:44] = '{
    8'h11, 8'h22, 8'h12, 8'h22, 8'h12, 8'h24, 8'h22, 8'h23, 8'h23, 8'h34, 8'h24, 8'h33,
    8'h13, 8'h23, 8'h23, 8'h33, 8'h14, 8'h14, 8'h13, 8'h13, 8'h13, 8'h13, 8'h24, 8'h23,
    8'h13, 8'h24, 8'h14, 8'h14, 8'h12, 8'h23, 8'h13, 8'h22, 8'h12, 8'h23, 8'h13, 8'h22,
    8'h24, 8'h34, 8'h11, 8'h12, 8'h11, 8'h11, 8'h11, 8'h11, 8'h11};
  logic clk_i, reset_n_i, issue_i, aux_external_i, external_bus_mode_select_i;
  logic [5:0] class_i, class_o;
  logic [1:0] ale_stretch_i, instr_bytes_o;
  logic [2:0] strobe_stretch_i;
  logic strobe_setup_hold_stretch_i, ready_o, busy_o, fetch_next_o, ext_access_o, illegal_o;
  logic [4:0] instr_cycles_o, cycle_index_o;
  sccit_note_t notes[$];
  sccit_note_t mon_n;
  int failures = 0, checks_done = 0, cnt = 0, cycles = 0, seed;
  logic [31:0] v;

  sccit_timing dut_u (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .issue_i(issue_i), .class_i(class_i),
    .aux_external_i(aux_external_i), .external_bus_mode_select_i(external_bus_mode_select_i),
    .ale_stretch_i(ale_stretch_i), .strobe_stretch_i(strobe_stretch_i),
    .strobe_setup_hold_stretch_i(strobe_setup_hold_stretch_i), .ready_o(ready_o),
    .busy_o(busy_o), .fetch_next_o(fetch_next_o), .instr_bytes_o(instr_bytes_o),
    .instr_cycles_o(instr_cycles_o), .cycle_index_o(cycle_index_o), .class_o(class_o),
    .ext_access_o(ext_access_o), .illegal_o(illegal_o));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // issue_i stays high on return so back-to-back takes need no extra edge
  task automatic issue(input logic [5:0] k, input logic x, input logic m,
                       input logic [1:0] a, input logic [2:0] s, input logic h);
    sccit_note_t n;
    n.k = k;
    n.x = x && k >= `SCCIT_AUX_RD_8 && k <= `SCCIT_AUX_WR_16;
    n.il = k > `SCCIT_SWAP_A;
    n.b = n.il ? 2'h1 : sccit_tbl[k][5:4];
    n.c = n.il ? 5'h01 : {1'b0, sccit_tbl[k][3:0]};
    if (n.x) n.c = 5'(m ? 5'h03 + s + 2 * h : 5'h05 + 2 * a + s + 2 * h);
    issue_i = 1'b1;
    class_i = k;
    aux_external_i = x;
    external_bus_mode_select_i = m;
    ale_stretch_i = a;
    strobe_stretch_i = s;
    strobe_setup_hold_stretch_i = h;
    while (ready_o !== 1'b1) begin
      @(posedge clk_i);
      #1;
    end
    @(posedge clk_i);
    notes.push_back(n);
    #1;
  endtask

  task automatic idle();
    issue_i = 1'b0;
    @(posedge clk_i);
    #1;
  endtask

  always @(negedge clk_i) begin
    if (!reset_n_i) cnt = 0;
    else begin
      if (busy_o === 1'b1) cnt++;
      if (fetch_next_o === 1'b1) begin
        if (notes.size() == 0) check(32'h0000_0001, 32'h0000_0000);
        else begin
          mon_n = notes.pop_front();
          check(cnt, mon_n.c);
          check(instr_cycles_o, mon_n.c);
          check(instr_bytes_o, mon_n.b);
          check(class_o, mon_n.k);
          check({ext_access_o, illegal_o}, {mon_n.x, mon_n.il});
          check(cycle_index_o, mon_n.c - 5'h01);
        end
        cnt = 0;
      end
    end
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      conclude();
    end
  end

  initial begin
    seed = 46663;
    {issue_i, class_i, aux_external_i, external_bus_mode_select_i} = '0;
    {ale_stretch_i, strobe_stretch_i, strobe_setup_hold_stretch_i} = '0;
    reset_n_i = 1'b0;
    repeat (20) @(posedge clk_i);
    #1 reset_n_i = 1'b1;
    for (int r = 0; r < 3; r++) begin
      for (int k = 0; k < 45; k++) begin
        v = $random(seed);
        issue(k[5:0], v[0], v[1], v[3:2], v[6:4], v[7]);
        if (v[8] && r > 0) idle();
      end
      $display("class sweep %0d done", r);
    end
    // stretch extremes in both bus modes, then unknown codes
    issue(`SCCIT_AUX_RD_16, 1'b1, 1'b0, 2'h3, 3'h7, 1'b1);
    issue(`SCCIT_AUX_WR_8, 1'b1, 1'b1, 2'h3, 3'h7, 1'b1);
    issue(`SCCIT_AUX_WR_16, 1'b1, 1'b1, 2'h0, 3'h0, 1'b0);
    issue(`SCCIT_AUX_RD_8, 1'b1, 1'b0, 2'h0, 3'h0, 1'b0);
    issue(`SCCIT_AUX_RD_8, 1'b0, 1'b0, 2'h3, 3'h7, 1'b1);
    issue(6'h2d, 1'b0, 1'b0, 2'h0, 3'h0, 1'b0);
    issue(6'h3f, 1'b1, 1'b0, 2'h0, 3'h0, 1'b0);
    idle();
    $display("stretch and unknown code test done");
    // reset in the middle of a four-cycle move
    issue_i = 1'b1;
    class_i = `SCCIT_MOV_DIR_DIR;
    @(posedge clk_i);
    #1 issue_i = 1'b0;
    @(posedge clk_i);
    #1 reset_n_i = 1'b0;
    @(posedge clk_i);
    #1 check({busy_o, fetch_next_o, ready_o}, 32'h0000_0001);
    check({instr_bytes_o, instr_cycles_o, cycle_index_o, class_o, ext_access_o, illegal_o}, 0);
    reset_n_i = 1'b1;
    issue(`SCCIT_CLEAR_A, 1'b0, 1'b0, 2'h0, 3'h0, 1'b0);
    idle();
    repeat (3) @(posedge clk_i);
    check(notes.size(), 32'h0000_0000);
    $display("mid-run reset test done");
    conclude();
  end
endmodule // single_clock_cpu_instruction_timing_test
